// ---- rtl/sxd_pkg.sv ----
// shared constants, enums and helpers for the field decoder
package sxd_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;
    localparam int IMM_W = 8;
    localparam int DISP_W = 12;
    localparam int SEL_W = 4;
    localparam int TRAP_SHIFT = 2;

    // field positions
    localparam int MAJ_LSB = 12;
    localparam int RN_LSB = 8;
    localparam int RM_LSB = 4;
    localparam int SUB_LSB = 0;
    localparam int D4_LSB = 0;
    localparam int D8_MSB = 7;
    localparam int D12_MSB = 11;

    localparam logic [SEL_W-1:0] SEL_REG0 = 4'h0;
    localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;

    // major group codes in bits 15..12
    localparam logic [3:0] MAJ_ZERO = 4'h0;
    localparam logic [3:0] MAJ_N = 4'h1;
    localparam logic [3:0] MAJ_M = 4'h2;
    localparam logic [3:0] MAJ_NM = 4'h3;
    localparam logic [3:0] MAJ_MD = 4'h4;
    localparam logic [3:0] MAJ_ND4 = 4'h5;
    localparam logic [3:0] MAJ_NMD_ST = 4'h6;
    localparam logic [3:0] MAJ_NMD_LD = 4'h7;
    localparam logic [3:0] MAJ_D = 4'h8;
    localparam logic [3:0] MAJ_D12 = 4'h9;
    localparam logic [3:0] MAJ_ND8 = 4'ha;
    localparam logic [3:0] MAJ_I = 4'hb;
    localparam logic [3:0] MAJ_NI_ADD = 4'hc;
    localparam logic [3:0] MAJ_NI_MOV = 4'hd;

    // sub codes, n and m formats (bits 3..0)
    localparam logic [3:0] SUB_N_DIRECT = 4'h0;
    localparam logic [3:0] SUB_N_CTRL = 4'h1;
    localparam logic [3:0] SUB_N_CTRL_PREDEC = 4'h2;
    localparam logic [3:0] SUB_M_CTRL = 4'h0;
    localparam logic [3:0] SUB_M_CTRL_POSTINC = 4'h1;
    localparam logic [3:0] SUB_M_JUMP = 4'h2;
    // sub codes, nm format (bits 3..0)
    localparam logic [3:0] SUB_NM_DIRECT = 4'h0;
    localparam logic [3:0] SUB_NM_STORE = 4'h1;
    localparam logic [3:0] SUB_NM_POSTINC = 4'h2;
    localparam logic [3:0] SUB_NM_PREDEC = 4'h3;
    localparam logic [3:0] SUB_NM_INDEXED = 4'h4;
    localparam logic [3:0] SUB_NM_MAC = 4'h5;
    // sub codes, d and i formats (bits 11..8)
    localparam logic [3:0] SUB_D_GBP_LD = 4'h0;
    localparam logic [3:0] SUB_D_GBP_ST = 4'h1;
    localparam logic [3:0] SUB_D_PC_ADDR = 4'h2;
    localparam logic [3:0] SUB_D_BRANCH = 4'h3;
    localparam logic [3:0] SUB_I_LOGIC = 4'h0;
    localparam logic [3:0] SUB_I_LOGIC_MEM = 4'h1;
    localparam logic [3:0] SUB_I_TRAP = 4'h2;
    localparam logic [3:0] SUB_I_CMPEQ = 4'h3;

    typedef enum logic [11:0] {
        FMT_ZERO = 12'h001, FMT_N = 12'h002, FMT_M = 12'h004,
        FMT_NM = 12'h008, FMT_MD = 12'h010, FMT_ND4 = 12'h020,
        FMT_NMD = 12'h040, FMT_D = 12'h080, FMT_D12 = 12'h100,
        FMT_ND8 = 12'h200, FMT_I = 12'h400, FMT_NI = 12'h800
    } sxd_fmt_e;

    typedef enum logic [13:0] {
        MODE_NONE = 14'h0001, MODE_DIRECT = 14'h0002,
        MODE_INDIRECT = 14'h0004, MODE_POSTINC = 14'h0008,
        MODE_PREDEC = 14'h0010, MODE_IDX_R0 = 14'h0020,
        MODE_DISP_REG = 14'h0040, MODE_DISP_GBP = 14'h0080,
        MODE_DISP_PC = 14'h0100, MODE_IMM = 14'h0200,
        MODE_CTRL = 14'h0400, MODE_ACC = 14'h0800,
        MODE_REG0 = 14'h1000, MODE_IDX_GBP = 14'h2000
    } sxd_mode_e;

    typedef enum logic [3:0] {
        EXT_NONE = 4'h1, EXT_ZERO = 4'h2, EXT_SIGN = 4'h4, EXT_TRAP = 4'h8
    } sxd_ext_e;

    typedef enum logic [1:0] {
        ST_EMPTY = 2'h1, ST_FULL = 2'h2
    } sxd_state_e;

    function automatic logic [SEL_W-1:0] sxd_nibble(
        input logic [WORD_W-1:0] w, input int lsb);
        sxd_nibble = w[lsb +: SEL_W];
    endfunction
endpackage

// ---- rtl/sxd_dec_if.sv ----
// carrier between decoder top, classifier and immediate extender
`timescale 1ns/1ps
interface sxd_dec_if;
    import sxd_pkg::*;
    logic [WORD_W-1:0] word;
    sxd_fmt_e fmt;
    sxd_mode_e src_mode;
    sxd_mode_e dst_mode;
    sxd_ext_e ext_kind;
    logic illegal;
    logic mac;
    logic [DATA_W-1:0] imm_ext;
    modport top (output word, input fmt, src_mode, dst_mode, ext_kind,
        illegal, mac, imm_ext);
    modport cls (input word, output fmt, src_mode, dst_mode, ext_kind,
        illegal, mac);
    modport ext (input word, ext_kind, output imm_ext);
endinterface

// ---- rtl/sxd_classify.sv ----
// opcode classifier: format and operand roles from opcode bits
`timescale 1ns/1ps
module sxd_classify import sxd_pkg::*; (
    sxd_dec_if.cls dif
);
    logic [3:0] maj;
    logic [3:0] sub_lo;
    logic [3:0] sub_hi;
    assign maj = sxd_nibble(dif.word, MAJ_LSB);
    assign sub_lo = sxd_nibble(dif.word, SUB_LSB);
    assign sub_hi = sxd_nibble(dif.word, RN_LSB);

    always_comb begin
        dif.fmt = FMT_ZERO;
        dif.src_mode = MODE_NONE;
        dif.dst_mode = MODE_NONE;
        dif.ext_kind = EXT_NONE;
        dif.illegal = 1'b0;
        dif.mac = 1'b0;
        case (maj)
            MAJ_ZERO: dif.fmt = FMT_ZERO;
            MAJ_N: begin
                dif.fmt = FMT_N;
                case (sub_lo)
                    SUB_N_DIRECT: dif.dst_mode = MODE_DIRECT;
                    SUB_N_CTRL: begin
                        dif.src_mode = MODE_CTRL;
                        dif.dst_mode = MODE_DIRECT;
                    end
                    SUB_N_CTRL_PREDEC: begin
                        dif.src_mode = MODE_CTRL;
                        dif.dst_mode = MODE_PREDEC;
                    end
                    default: dif.illegal = 1'b1;
                endcase
            end
            MAJ_M: begin
                dif.fmt = FMT_M;
                case (sub_lo)
                    SUB_M_CTRL: begin
                        dif.src_mode = MODE_DIRECT;
                        dif.dst_mode = MODE_CTRL;
                    end
                    SUB_M_CTRL_POSTINC: begin
                        dif.src_mode = MODE_POSTINC;
                        dif.dst_mode = MODE_CTRL;
                    end
                    SUB_M_JUMP: dif.src_mode = MODE_INDIRECT;
                    default: dif.illegal = 1'b1;
                endcase
            end
            MAJ_NM: begin
                dif.fmt = FMT_NM;
                dif.src_mode = MODE_DIRECT;
                case (sub_lo)
                    SUB_NM_DIRECT: dif.dst_mode = MODE_DIRECT;
                    SUB_NM_STORE: dif.dst_mode = MODE_INDIRECT;
                    SUB_NM_POSTINC: begin
                        dif.src_mode = MODE_POSTINC;
                        dif.dst_mode = MODE_DIRECT;
                    end
                    SUB_NM_PREDEC: dif.dst_mode = MODE_PREDEC;
                    SUB_NM_INDEXED: dif.dst_mode = MODE_IDX_R0;
                    SUB_NM_MAC: begin
                        dif.src_mode = MODE_POSTINC;
                        dif.dst_mode = MODE_ACC;
                        dif.mac = 1'b1;
                    end
                    default: dif.illegal = 1'b1;
                endcase
            end
            MAJ_MD: begin
                dif.fmt = FMT_MD;
                dif.src_mode = MODE_DISP_REG;
                dif.dst_mode = MODE_REG0;
            end
            MAJ_ND4: begin
                dif.fmt = FMT_ND4;
                dif.src_mode = MODE_REG0;
                dif.dst_mode = MODE_DISP_REG;
            end
            MAJ_NMD_ST: begin
                dif.fmt = FMT_NMD;
                dif.src_mode = MODE_DIRECT;
                dif.dst_mode = MODE_DISP_REG;
            end
            MAJ_NMD_LD: begin
                dif.fmt = FMT_NMD;
                dif.src_mode = MODE_DISP_REG;
                dif.dst_mode = MODE_DIRECT;
            end
            MAJ_D: begin
                dif.fmt = FMT_D;
                case (sub_hi)
                    SUB_D_GBP_LD: begin
                        dif.src_mode = MODE_DISP_GBP;
                        dif.dst_mode = MODE_REG0;
                    end
                    SUB_D_GBP_ST: begin
                        dif.src_mode = MODE_REG0;
                        dif.dst_mode = MODE_DISP_GBP;
                    end
                    SUB_D_PC_ADDR: begin
                        dif.src_mode = MODE_DISP_PC;
                        dif.dst_mode = MODE_REG0;
                    end
                    SUB_D_BRANCH: dif.src_mode = MODE_DISP_PC;
                    default: dif.illegal = 1'b1;
                endcase
            end
            MAJ_D12: begin
                dif.fmt = FMT_D12;
                dif.src_mode = MODE_DISP_PC;
            end
            MAJ_ND8: begin
                dif.fmt = FMT_ND8;
                dif.src_mode = MODE_DISP_PC;
                dif.dst_mode = MODE_DIRECT;
            end
            MAJ_I: begin
                dif.fmt = FMT_I;
                dif.src_mode = MODE_IMM;
                case (sub_hi)
                    SUB_I_LOGIC: begin
                        dif.dst_mode = MODE_REG0;
                        dif.ext_kind = EXT_ZERO;
                    end
                    SUB_I_LOGIC_MEM: begin
                        dif.dst_mode = MODE_IDX_GBP;
                        dif.ext_kind = EXT_ZERO;
                    end
                    SUB_I_TRAP: dif.ext_kind = EXT_TRAP;
                    SUB_I_CMPEQ: begin
                        dif.dst_mode = MODE_REG0;
                        dif.ext_kind = EXT_SIGN;
                    end
                    default: dif.illegal = 1'b1;
                endcase
            end
            MAJ_NI_ADD, MAJ_NI_MOV: begin
                dif.fmt = FMT_NI;
                dif.src_mode = MODE_IMM;
                dif.dst_mode = MODE_DIRECT;
                dif.ext_kind = EXT_SIGN;
            end
            default: dif.illegal = 1'b1;
        endcase
    end
endmodule // sxd_classify

// ---- rtl/sxd_extend.sv ----
// 8-bit immediate extender
`timescale 1ns/1ps
module sxd_extend import sxd_pkg::*; (
    sxd_dec_if.ext dif
);
    logic [IMM_W-1:0] imm8;
    assign imm8 = dif.word[IMM_W-1:0];

    always_comb begin
        case (dif.ext_kind)
            EXT_ZERO: dif.imm_ext = {{(DATA_W-IMM_W){1'b0}}, imm8};
            EXT_SIGN: dif.imm_ext = {{(DATA_W-IMM_W){imm8[IMM_W-1]}}, imm8};
            // trap vector: zero-extended, times four
            EXT_TRAP: dif.imm_ext = {{(DATA_W-IMM_W-TRAP_SHIFT){1'b0}},
                imm8, {TRAP_SHIFT{1'b0}}};
            default: dif.imm_ext = '0;
        endcase
    end
endmodule // sxd_extend

// ---- rtl/sxd_decoder.sv ----
// 16-bit instruction field decoder, one-entry output stage
`timescale 1ns/1ps
module sxd_decoder import sxd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic fetch_valid,
    input wire logic [WORD_W-1:0] fetch_word,
    output logic fetch_ready,
    input wire logic exec_ready,
    output logic dec_valid,
    output logic [WORD_W-1:0] dec_opcode,
    output sxd_fmt_e dec_format,
    output sxd_mode_e dec_src_mode,
    output sxd_mode_e dec_dst_mode,
    output logic [SEL_W-1:0] dec_src_sel,
    output logic [SEL_W-1:0] dec_dst_sel,
    output logic [SEL_W-1:0] dec_src2_sel,
    output logic [SEL_W-1:0] dec_ctrl_sel,
    output logic [DISP_W-1:0] dec_disp,
    output logic [DATA_W-1:0] dec_imm,
    output logic dec_mac,
    output logic dec_uses_reg0,
    output logic dec_illegal
);
    sxd_dec_if dif ();

    sxd_classify u_classify (
        .dif(dif)
    );

    sxd_extend u_extend (
        .dif(dif)
    );

    // handshake state
    sxd_state_e state;
    sxd_state_e next_state;
    logic take;
    logic drain;
    logic next_fetch_ready;

    // decoded field values for the incoming word
    logic [SEL_W-1:0] f_rn;
    logic [SEL_W-1:0] f_rm;
    logic [SEL_W-1:0] f_d4;
    logic [IMM_W-1:0] f_d8;
    logic [DISP_W-1:0] f_d12;
    logic [SEL_W-1:0] next_src_sel;
    logic [SEL_W-1:0] next_dst_sel;
    logic [SEL_W-1:0] next_src2_sel;
    logic [SEL_W-1:0] next_ctrl_sel;
    logic [DISP_W-1:0] next_disp;
    logic next_uses_reg0;

    // output stage next values
    logic next_valid;
    logic [WORD_W-1:0] next_opcode;
    sxd_fmt_e next_format;
    sxd_mode_e next_src_mode;
    sxd_mode_e next_dst_mode;
    logic [SEL_W-1:0] nx_src_sel;
    logic [SEL_W-1:0] nx_dst_sel;
    logic [SEL_W-1:0] nx_src2_sel;
    logic [SEL_W-1:0] nx_ctrl_sel;
    logic [DISP_W-1:0] nx_disp;
    logic [DATA_W-1:0] next_imm;
    logic next_mac;
    logic nx_uses_reg0;
    logic next_illegal;

    assign dif.word = fetch_word;
    assign f_rn = sxd_nibble(fetch_word, RN_LSB);
    assign f_rm = sxd_nibble(fetch_word, RM_LSB);
    assign f_d4 = sxd_nibble(fetch_word, D4_LSB);
    assign f_d8 = fetch_word[D8_MSB:0];
    assign f_d12 = fetch_word[D12_MSB:0];

    assign take = fetch_valid && fetch_ready;
    assign drain = dec_valid && exec_ready;

    // field routing by format
    always_comb begin
        next_src_sel = SEL_NONE;
        next_dst_sel = SEL_NONE;
        next_src2_sel = SEL_NONE;
        next_ctrl_sel = SEL_NONE;
        next_disp = '0;
        case (dif.fmt)
            FMT_N: next_dst_sel = f_rn;
            FMT_M: next_src_sel = f_rn;
            FMT_NM: begin
                next_src_sel = f_rm;
                if (dif.mac) begin
                    next_src2_sel = f_rn;
                end else begin
                    next_dst_sel = f_rn;
                end
            end
            FMT_MD: begin
                next_src_sel = f_rm;
                next_dst_sel = SEL_REG0;
                next_disp = {{(DISP_W-SEL_W){1'b0}}, f_d4};
            end
            FMT_ND4: begin
                next_src_sel = SEL_REG0;
                next_dst_sel = f_rm;
                next_disp = {{(DISP_W-SEL_W){1'b0}}, f_d4};
            end
            FMT_NMD: begin
                next_dst_sel = f_rn;
                next_src_sel = f_rm;
                next_disp = {{(DISP_W-SEL_W){1'b0}}, f_d4};
            end
            FMT_D: begin
                next_disp = {{(DISP_W-IMM_W){1'b0}}, f_d8};
                next_src_sel = SEL_REG0;
                next_dst_sel = SEL_REG0;
            end
            FMT_D12: next_disp = f_d12;
            FMT_ND8: begin
                next_dst_sel = f_rn;
                next_disp = {{(DISP_W-IMM_W){1'b0}}, f_d8};
            end
            FMT_I: next_dst_sel = SEL_REG0;
            FMT_NI: next_dst_sel = f_rn;
            default: next_disp = '0;
        endcase
        // control or system register index rides in bits 7..4
        if (dif.src_mode == MODE_CTRL || dif.dst_mode == MODE_CTRL) begin
            next_ctrl_sel = f_rm;
        end
        next_uses_reg0 = (dif.src_mode == MODE_REG0)
            || (dif.dst_mode == MODE_REG0)
            || (dif.dst_mode == MODE_IDX_R0)
            || (dif.dst_mode == MODE_IDX_GBP);
    end

    // one-entry stage; ready is registered so fetch never sees a comb path
    // from exec_ready, at the cost of one bubble after each drain
    always_comb begin
        next_state = state;
        next_valid = dec_valid;
        next_opcode = dec_opcode;
        next_format = dec_format;
        next_src_mode = dec_src_mode;
        next_dst_mode = dec_dst_mode;
        nx_src_sel = dec_src_sel;
        nx_dst_sel = dec_dst_sel;
        nx_src2_sel = dec_src2_sel;
        nx_ctrl_sel = dec_ctrl_sel;
        nx_disp = dec_disp;
        next_imm = dec_imm;
        next_mac = dec_mac;
        nx_uses_reg0 = dec_uses_reg0;
        next_illegal = dec_illegal;
        case (state)
            ST_EMPTY: begin
                if (take) begin
                    next_state = ST_FULL;
                    next_valid = 1'b1;
                    next_opcode = fetch_word;
                    next_format = dif.fmt;
                    next_src_mode = dif.src_mode;
                    next_dst_mode = dif.dst_mode;
                    nx_src_sel = next_src_sel;
                    nx_dst_sel = next_dst_sel;
                    nx_src2_sel = next_src2_sel;
                    nx_ctrl_sel = next_ctrl_sel;
                    nx_disp = next_disp;
                    next_imm = dif.imm_ext;
                    next_mac = dif.mac;
                    nx_uses_reg0 = next_uses_reg0;
                    next_illegal = dif.illegal;
                end
            end
            ST_FULL: begin
                if (drain) begin
                    next_state = ST_EMPTY;
                    next_valid = 1'b0;
                end
            end
            default: begin
                next_state = ST_EMPTY;
                next_valid = 1'b0;
            end
        endcase
        next_fetch_ready = (next_state == ST_EMPTY);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_EMPTY;
            fetch_ready <= 1'b0;
            dec_valid <= 1'b0;
            dec_opcode <= '0;
            dec_format <= FMT_ZERO;
            dec_src_mode <= MODE_NONE;
            dec_dst_mode <= MODE_NONE;
            dec_src_sel <= SEL_NONE;
            dec_dst_sel <= SEL_NONE;
            dec_src2_sel <= SEL_NONE;
            dec_ctrl_sel <= SEL_NONE;
            dec_disp <= '0;
            dec_imm <= '0;
            dec_mac <= 1'b0;
            dec_uses_reg0 <= 1'b0;
            dec_illegal <= 1'b0;
        end else begin
            state <= next_state;
            fetch_ready <= next_fetch_ready;
            dec_valid <= next_valid;
            dec_opcode <= next_opcode;
            dec_format <= next_format;
            dec_src_mode <= next_src_mode;
            dec_dst_mode <= next_dst_mode;
            dec_src_sel <= nx_src_sel;
            dec_dst_sel <= nx_dst_sel;
            dec_src2_sel <= nx_src2_sel;
            dec_ctrl_sel <= nx_ctrl_sel;
            dec_disp <= nx_disp;
            dec_imm <= next_imm;
            dec_mac <= next_mac;
            dec_uses_reg0 <= nx_uses_reg0;
            dec_illegal <= next_illegal;
        end
    end
endmodule // sxd_decoder

// ---- sim/sxd_decoder_props.sv ----
// concurrent checks on the decoder top ports
`timescale 1ns/1ps
module sxd_decoder_props import sxd_pkg::*; (
    input logic clk,
    input logic rst,
    input logic fetch_valid,
    input logic [WORD_W-1:0] fetch_word,
    input logic fetch_ready,
    input logic exec_ready,
    input logic dec_valid,
    input logic [WORD_W-1:0] dec_opcode,
    input sxd_mode_e dec_src_mode,
    input sxd_mode_e dec_dst_mode,
    input logic [SEL_W-1:0] dec_src_sel,
    input logic [SEL_W-1:0] dec_dst_sel,
    input logic [SEL_W-1:0] dec_src2_sel,
    input logic [DISP_W-1:0] dec_disp,
    input logic [DATA_W-1:0] dec_imm,
    input logic dec_mac
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence take_s;
        fetch_valid && fetch_ready;
    endsequence
    sequence take_maj(logic [3:0] mj);
        take_s ##0 fetch_word[15:12] == mj;
    endsequence
    take_answer_a: assert property (take_s |=> dec_valid && !fetch_ready
        && dec_opcode == $past(fetch_word)) else $error("word not decoded");
    hold_stall_a: assert property (dec_valid && !exec_ready |=> dec_valid
        && $stable(dec_opcode) && $stable(dec_imm) && $stable(dec_disp))
        else $error("fields moved while stalled");
    drain_ready_a: assert property (dec_valid && exec_ready |=>
        !dec_valid && fetch_ready) else $error("drain handshake wrong");
    nm_fields_a: assert property (take_maj(MAJ_NM) ##0 fetch_word[3:0] < 4'h5
        |=> dec_dst_sel == $past(fetch_word[11:8])
        && dec_src_sel == $past(fetch_word[7:4])) else $error("nm regs");
    mac_route_a: assert property (take_maj(MAJ_NM) ##0 fetch_word[3:0] ==
        SUB_NM_MAC |=> dec_mac && dec_dst_mode == MODE_ACC
        && dec_src2_sel == $past(fetch_word[11:8])) else $error("mac");
    jump_mode_a: assert property (take_maj(MAJ_M) ##0 fetch_word[3:0] ==
        SUB_M_JUMP |=> dec_src_mode == MODE_INDIRECT
        && dec_dst_mode == MODE_NONE) else $error("jump mode");
    nmd_disp_a: assert property (take_maj(MAJ_NMD_LD) or take_maj(MAJ_NMD_ST)
        |=> dec_disp == {8'h0, $past(fetch_word[3:0])}
        && dec_dst_sel == $past(fetch_word[11:8])) else $error("nmd");
    branch_disp_a: assert property (take_maj(MAJ_D12) |=>
        dec_disp == $past(fetch_word[11:0])) else $error("d12 disp");
    trap_imm_a: assert property (take_maj(MAJ_I) ##0 fetch_word[11:8] ==
        SUB_I_TRAP |=> dec_imm == {22'h0, $past(fetch_word[7:0]), 2'h0})
        else $error("trap imm");
    ni_sign_a: assert property (take_maj(MAJ_NI_ADD) |=>
        dec_imm == {{24{$past(fetch_word[7])}}, $past(fetch_word[7:0])})
        else $error("ni imm");
endmodule // sxd_decoder_props

// ---- sim/sxd_fetch_model.sv ----
// fetch stage and execution sink model
`timescale 1ns/1ps
module sxd_fetch_model import sxd_pkg::*; (
    input logic clk,
    input logic rst,
    input logic fetch_ready,
    input logic stall,
    output logic fetch_valid,
    output logic [WORD_W-1:0] fetch_word,
    output logic exec_ready
);
    logic [WORD_W-1:0] q[$];
    logic took;
    initial begin
        fetch_valid = 0;
        fetch_word = '0;
        exec_ready = 0;
        took = 0;
    end
    // sampled off-edge so the design's own update cannot race it
    always @(negedge clk) took = fetch_valid && fetch_ready && !rst;
    always @(posedge clk) begin
        #1;
        if (took) void'(q.pop_front());
        fetch_valid = q.size() > 0;
        if (fetch_valid) fetch_word = q[0]; // held until taken
        else if (took) fetch_word = ~fetch_word; // word inverted, so the taken word does not stay on the bus
        exec_ready = !stall;
    end
endmodule // sxd_fetch_model

// ---- sim/sxd_decoder_bench.sv ----
// self-checking bench for the field decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    if ((ex) >= 0) begin \
        checks_done++; \
        if ((ex) !== (got)) begin \
            num_errors++; \
            $display("mismatch %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module sxd_decoder_bench import sxd_pkg::*;;
    logic clk, rst, fetch_valid, fetch_ready, exec_ready, dec_valid, stall;
    logic [WORD_W-1:0] fetch_word, dec_opcode, w;
    sxd_fmt_e dec_format;
    sxd_mode_e dec_src_mode, dec_dst_mode;
    logic [SEL_W-1:0] dec_src_sel, dec_dst_sel, dec_src2_sel, dec_ctrl_sel;
    logic [DISP_W-1:0] dec_disp;
    logic [DATA_W-1:0] dec_imm;
    logic dec_mac, dec_uses_reg0, dec_illegal;
    logic [31:0] seed;
    logic [WORD_W-1:0] expq[$];
    longint e[9];
    int num_errors, checks_done;
    localparam int FB[14] = '{0, 1, 2, 3, 4, 5, 6, 6, 7, 8, 9, 10, 11, 11};
    sxd_decoder DUT (.clk, .rst, .fetch_valid, .fetch_word, .fetch_ready,
        .exec_ready, .dec_valid, .dec_opcode, .dec_format, .dec_src_mode,
        .dec_dst_mode, .dec_src_sel, .dec_dst_sel, .dec_src2_sel,
        .dec_ctrl_sel, .dec_disp, .dec_imm, .dec_mac, .dec_uses_reg0,
        .dec_illegal);
    sxd_fetch_model P (.clk, .rst, .fetch_ready, .stall, .fetch_valid,
        .fetch_word, .exec_ready);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // -1 marks a field the encoding leaves open
    function automatic void model(input logic [15:0] x, output longint r[9]);
        logic [3:0] mj, n, m, s;
        longint sx;
        mj = x[15:12];
        n = x[11:8];
        m = x[7:4];
        s = x[3:0];
        sx = longint'({{24{x[7]}}, x[7:0]});
        r = '{-1, -1, -1, 0, 0, 0, 0, 0, 0};
        r[0] = (mj > 4'hd) ? -1 : longint'(1) << FB[mj];
        case (mj)
            4'h1: begin
                r[2] = s > 2 ? -1 : int'(n);
                r[6] = s > 2;
                r[7] = (s == 1 || s == 2) ? m : 0;
            end
            4'h2: begin
                r[1] = s > 2 ? -1 : int'(n);
                r[6] = s > 2;
                r[7] = s < 2 ? m : 0;
            end
            4'h3: begin
                r[2] = s > 4 ? -1 : int'(n);
                r[1] = s > 5 ? -1 : int'(m);
                r[5] = s == 5;
                r[6] = s > 5;
                r[8] = s == 4;
            end
            4'h4: begin r[1] = m; r[2] = 0; r[3] = s; r[8] = 1; end
            4'h5: begin r[1] = 0; r[2] = m; r[3] = s; r[8] = 1; end
            4'h6, 4'h7: begin r[2] = n; r[1] = m; r[3] = s; end
            4'h8: begin
                r[1] = 0;
                r[2] = 0;
                r[3] = x[7:0];
                r[6] = n > 3;
                r[8] = n < 3;
            end
            4'h9: r[3] = x[11:0];
            4'ha: begin r[2] = n; r[3] = x[7:0]; end
            4'hb: begin
                r[4] = n > 3 ? -1 : n == 2 ? x[7:0] * 4 : n == 3 ? sx : x[7:0];
                r[6] = n > 3;
                r[8] = n < 4 && n != 2;
            end
            4'hc, 4'hd: begin r[2] = n; r[4] = sx; end
            default: if (mj > 4'hd) r = '{-1, -1, -1, -1, -1, -1, 1, -1, -1};
        endcase
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_reset;
        `CHK("rst valid", 0, dec_valid)
        `CHK("rst ready", 0, fetch_ready)
        `CHK("rst format", FMT_ZERO, dec_format)
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // off-edge monitor: what is seen here is taken at the next rise
    always @(negedge clk) begin
        if (rst) expq.delete();
        else begin
            if (dec_valid && exec_ready) begin
                `CHK("queue", 1, expq.size() > 0)
                if (expq.size() > 0) begin
                    w = expq.pop_front();
                    model(w, e);
                    `CHK("opcode", longint'(w), dec_opcode)
                    `CHK("format", e[0], dec_format)
                    `CHK("src", e[1], dec_src_sel)
                    `CHK("dst", e[2], dec_dst_sel)
                    `CHK("disp", e[3], dec_disp)
                    `CHK("imm", e[4], dec_imm)
                    `CHK("mac", e[5], dec_mac)
                    `CHK("illegal", e[6], dec_illegal)
                    `CHK("ctrl", e[7], dec_ctrl_sel)
                    `CHK("reg0", e[8], dec_uses_reg0)
                end
            end
            if (fetch_valid && fetch_ready) expq.push_back(fetch_word);
        end
    end
    always @(posedge clk) begin
        #1;
        seed = lfsr(seed);
        stall = seed[0] & seed[1];
    end
    initial begin
        rst = 1;
        stall = 0;
        seed = 32'h3fe7fc3b;
        repeat (7) @(posedge clk);
        @(negedge clk) chk_reset();
        for (int i = 0; i < 16; i++)
            for (int j = 0; j < 6; j++)
                P.q.push_back({i[3:0], j[3:0], seed[7:4] ^ j[3:0], j[3:0]});
        for (int k = 0; k < 200; k++)
            P.q.push_back(16'(lfsr(seed + k) ^ k));
        @(posedge clk);
        #1 rst = 0;
        repeat (300) @(posedge clk);
        #1 rst = 1; // reset with a word in flight
        @(posedge clk);
        @(negedge clk) chk_reset();
        @(posedge clk);
        #1 rst = 0;
        for (int t = 0; t < 5000 && (P.q.size() > 0 || dec_valid); t++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        `CHK("left", 0, expq.size())
        end_of_test();
    end
    initial begin
        #(8 * 20000);
        num_errors++;
        end_of_test();
    end
endmodule // sxd_decoder_bench
bind sxd_decoder sxd_decoder_props u_props (.clk, .rst, .fetch_valid,
    .fetch_word, .fetch_ready, .exec_ready, .dec_valid, .dec_opcode,
    .dec_src_mode, .dec_dst_mode, .dec_src_sel, .dec_dst_sel, .dec_src2_sel,
    .dec_disp,
    .dec_imm, .dec_mac);
